// ---- design/tap_pkg.sv ----
// Purpose: Shared constants and types for the boundary-scan port and its test master
// Assumes: Both ends run on a 50 MHz core clock
// Notes: Master register map sits on a 32-bit APB slave, one word per register
package tap_pkg;
  // ************************************************************
  // Instruction register and opcodes
  // ************************************************************
  localparam int IR_W = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_SAMPLE = 4'h3;
  localparam logic [3:0] OP_CLAMP = 4'h5;
  localparam logic [3:0] OP_HIGHZ = 4'h7;
  localparam logic [3:0] OP_CLAMP_OFF = 4'h9;
  localparam logic [3:0] OP_INTEST = 4'hc;
  localparam logic [3:0] OP_IDCODE = 4'he;
  localparam logic [3:0] OP_BYPASS = 4'hf;
  localparam logic [3:0] CHAIN_SEL_BSCAN = 4'h3;
  localparam int ID_W = 32;
  // Arbitrary identification value, bit 0 set as the ID register requires
  localparam logic [31:0] IDCODE_DEFAULT = 32'h0a5c_3e01;

  // ************************************************************
  // Controller states
  // ************************************************************
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_t;

  // ************************************************************
  // Master register map and fields
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TX = 8'h04;
  localparam logic [7:0] REG_RX = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_KIND_LSB = 1;
  localparam int CTRL_LEN_LSB = 8;
  localparam int CTRL_TRST_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam logic [1:0] KIND_DR = 2'h0;
  localparam logic [1:0] KIND_IR = 2'h1;
  localparam logic [1:0] KIND_RESET = 2'h2;
  // Mode bit sequences, first bit in bit 0
  localparam logic [5:0] PRE_DR = 6'h01;
  localparam logic [2:0] PRE_DR_LEN = 3'h3;
  localparam logic [5:0] PRE_IR = 6'h03;
  localparam logic [2:0] PRE_IR_LEN = 3'h4;
  localparam logic [5:0] PRE_RESET = 6'h1f;
  localparam logic [2:0] PRE_RESET_LEN = 3'h6;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CORE_CLK_NS = 20;
  localparam int TCK_LOW_MIN_NS = 50;
  localparam int TCK_LOW_MIN_CYC = (TCK_LOW_MIN_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  // Extra cycles so data returns through both synchronisers in time
  localparam int SYNC_MARGIN_CYC = 5;
  localparam int TCK_HALF_DEFAULT = TCK_LOW_MIN_CYC + SYNC_MARGIN_CYC;
endpackage : tap_pkg

// ---- design/tap_link_if.sv ----
// Purpose: Five-wire test access link between master and device
// Assumes: The interface resolves the shared line from the tdo enable
// Notes: No clocking block; both ends sample on their own core clock
`timescale 1ns/100ps
interface tap_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic trst_n;
  logic tdo;
  logic tdo_oe;
  logic tdo_line;

  // Released line shows the inverse, so a sample taken outside the driven window stands out
  assign tdo_line = tdo_oe ? tdo : ~tdo;

  // ************************************************************
  // Party views
  // ************************************************************
  modport dev (input tck, input tms, input tdi, input trst_n, output tdo, output tdo_oe);
  modport ctl (output tck, output tms, output tdi, output trst_n, input tdo, input tdo_oe, input tdo_line);
endinterface : tap_link_if

// ---- design/jtag_test_master.sv ----
// Purpose: Test controller end: drives the link from APB-programmed shift jobs
// Assumes: Software keeps CTRL trst bit high before starting jobs
// Notes: Link clock made here by a divider; data is shifted LSB first
`timescale 1ns/100ps
module jtag_test_master
  import tap_pkg::*;
#(
  parameter int TCK_HALF = TCK_HALF_DEFAULT
)
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  tap_link_if.ctl LINK
);
  localparam logic [7:0] HALF_M1 = 8'(TCK_HALF - 1);
  localparam logic [7:0] FULL_M1 = 8'(2 * TCK_HALF - 1);

  typedef enum logic [1:0] {H_IDLE, H_PRE, H_SHIFT, H_POST} h_state_t;

  typedef struct packed {
    logic tdo_s1;
    logic tdo_s2;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic [7:0] cnt;
    h_state_t hs;
    logic [5:0] pre_pat;
    logic [2:0] pre_left;
    logic post2;
    logic [4:0] bit_idx;
    logic [4:0] len;
    logic [1:0] kind;
    logic [31:0] tx;
    logic [31:0] rx;
    logic done;
  } host_state_t;

  localparam host_state_t RST_VAL = '{hs: H_IDLE, default: '0};

  host_state_t r;
  host_state_t next_r;
  logic wr;
  logic busy;
  logic mapped;

  // ************************************************************
  // Bus decode
  // ************************************************************
  // Zero-wait slave: every access phase completes at once
  assign PREADY = 1'b1;
  assign wr = PSEL & PENABLE & PWRITE;
  assign busy = (r.hs != H_IDLE);
  assign mapped = (PADDR == REG_CTRL) | (PADDR == REG_TX) | (PADDR == REG_RX) | (PADDR == REG_STATUS);
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // Read mux, unmapped words read zero
  always_comb
  begin
    PRDATA = 32'h0000_0000;
    if (PADDR == REG_CTRL)
    begin
      PRDATA[CTRL_TRST_BIT] = r.trst_n;
      PRDATA[CTRL_LEN_LSB +: 5] = r.len;
      PRDATA[CTRL_KIND_LSB +: 2] = r.kind;
    end
    else if (PADDR == REG_TX)
      PRDATA = r.tx;
    else if (PADDR == REG_RX)
      PRDATA = r.rx;
    else if (PADDR == REG_STATUS)
    begin
      PRDATA[STAT_BUSY_BIT] = busy;
      PRDATA[STAT_DONE_BIT] = r.done;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  // TMS/TDI change only while TCK is low, so the device samples them settled
  always_comb
  begin
    next_r = r;
    next_r.tdo_s1 = LINK.tdo_line;
    next_r.tdo_s2 = r.tdo_s1;
    if (wr && PADDR == REG_TX && !busy)
      next_r.tx = PWDATA;
    if (wr && PADDR == REG_CTRL && !busy)
    begin
      next_r.trst_n = PWDATA[CTRL_TRST_BIT]; // Software must raise this before use
      next_r.kind = PWDATA[CTRL_KIND_LSB +: 2];
      next_r.len = PWDATA[CTRL_LEN_LSB +: 5];
      // A job is refused while the device is held in reset
      if (PWDATA[CTRL_GO_BIT] && PWDATA[CTRL_TRST_BIT])
      begin
        next_r.hs = H_PRE;
        next_r.done = 1'b0;
        next_r.cnt = 8'h00;
        next_r.tdi = 1'b0;
        next_r.post2 = 1'b0;
        next_r.bit_idx = 5'h00;
        next_r.rx = 32'h0000_0000;
        unique case (PWDATA[CTRL_KIND_LSB +: 2])
          KIND_IR:
          begin
            next_r.pre_pat = PRE_IR;
            next_r.pre_left = PRE_IR_LEN;
          end
          KIND_RESET:
          begin
            next_r.pre_pat = PRE_RESET;
            next_r.pre_left = PRE_RESET_LEN;
          end
          default:
          begin
            next_r.pre_pat = PRE_DR;
            next_r.pre_left = PRE_DR_LEN;
          end
        endcase
        next_r.tms = next_r.pre_pat[0];
      end
    end
    if (busy)
    begin
      next_r.cnt = r.cnt + 8'h01;
      if (r.cnt == HALF_M1)
      begin
        // Rising edge: device samples, master takes TDO
        next_r.tck = 1'b1;
        if (r.hs == H_SHIFT)
          next_r.rx[r.bit_idx] = r.tdo_s2;
      end
      if (r.cnt == FULL_M1)
      begin
        next_r.tck = 1'b0;
        next_r.cnt = 8'h00;
        unique case (r.hs)
          H_PRE:
            if (r.pre_left > 3'h1)
            begin
              next_r.pre_pat = {1'b0, r.pre_pat[5:1]};
              next_r.pre_left = r.pre_left - 3'h1;
              next_r.tms = r.pre_pat[1];
            end
            else if (r.kind == KIND_RESET)
            begin
              next_r.hs = H_IDLE;
              next_r.done = 1'b1;
            end
            else
            begin
              next_r.hs = H_SHIFT;
              next_r.tms = (r.len == 5'h00);
              next_r.tdi = r.tx[0];
            end
          H_SHIFT:
            if (r.bit_idx == r.len)
            begin
              next_r.hs = H_POST;
              next_r.tms = 1'b1;
              next_r.tdi = 1'b0;
            end
            else
            begin
              next_r.bit_idx = r.bit_idx + 5'h01;
              next_r.tms = (r.bit_idx + 5'h01 == r.len);
              next_r.tdi = r.tx[r.bit_idx + 5'h01];
            end
          H_POST:
            if (!r.post2)
            begin
              next_r.post2 = 1'b1;
              next_r.tms = 1'b0;
            end
            else
            begin
              next_r.hs = H_IDLE;
              next_r.done = 1'b1;
            end
          H_IDLE:
            next_r.hs = H_IDLE;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      r <= RST_VAL;
    else
      r <= next_r;
  end

  assign LINK.tck = r.tck;
  assign LINK.tms = r.tms;
  assign LINK.tdi = r.tdi;
  assign LINK.trst_n = r.trst_n;
endmodule : jtag_test_master

// ---- design/boundary_scan_tap.sv ----
// Purpose: Boundary-scan access port with bypass, ID and boundary register
// Assumes: Link pins are asynchronous to CORE_CLK and slower than a quarter of it
// Notes: Link edges are found by sampling; pad inputs pass a synchroniser first
`timescale 1ns/100ps
module boundary_scan_tap
  import tap_pkg::*;
#(
  parameter int NPAD = 4,
  parameter logic [ID_W-1:0] IDCODE = IDCODE_DEFAULT
)
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  tap_link_if.dev LINK,
  input wire logic [NPAD-1:0] PAD_IN,
  output logic [NPAD-1:0] PAD_OUT,
  output logic [NPAD-1:0] PAD_OE,
  input wire logic [NPAD-1:0] CORE_OUT,
  input wire logic [NPAD-1:0] CORE_OE,
  output logic [NPAD-1:0] CORE_IN,
  input wire logic CHAIN_SEL_WE,
  input wire logic [IR_W-1:0] CHAIN_SEL_WDATA,
  output logic [IR_W-1:0] CHAIN_SEL,
  output logic [IR_W-1:0] INSTR,
  output logic SYSTEM_MODE
);
  // Three cells per pad: input, output data, output enable
  localparam int BS_W = 3 * NPAD;

  typedef struct packed {
    logic tck_s1;
    logic tck_s2;
    logic tck_d;
    logic tms_s1;
    logic tms_s2;
    logic tdi_s1;
    logic tdi_s2;
    logic trst_s1;
    logic trst_s2;
    logic [NPAD-1:0] pin_s1;
    logic [NPAD-1:0] pin_s2;
    tap_state_t st;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic bypass;
    logic [ID_W-1:0] id_sh;
    logic [BS_W-1:0] bs_sh;
    logic [BS_W-1:0] bs_upd;
    logic [IR_W-1:0] chain_sel;
    logic tdo;
    logic tdo_oe;
  } dev_state_t;

  // Reset leaves the identification instruction and the boundary chain selected
  localparam dev_state_t RST_VAL = '{st: TLR, ir: OP_IDCODE, chain_sel: CHAIN_SEL_BSCAN, default: '0};

  dev_state_t r;
  dev_state_t next_r;
  logic rise;
  logic fall;
  logic chain_ok;
  logic bs_sel;
  logic id_sel;
  logic test_mode;
  logic clamp_drv;
  logic outs_off;
  logic [BS_W-1:0] cap_vec;

  // ************************************************************
  // Controller next state
  // ************************************************************
  // Standard sixteen-state walk except UPD_IR, which goes to SEL_IR on TMS high; TMS taken at each rising edge
  function automatic tap_state_t tap_next(input tap_state_t s, input logic tms);
    unique case (s)
      TLR: tap_next = tms ? TLR : RTI;
      RTI: tap_next = tms ? SEL_DR : RTI;
      SEL_DR: tap_next = tms ? SEL_IR : CAP_DR;
      CAP_DR: tap_next = tms ? EX1_DR : SH_DR;
      SH_DR: tap_next = tms ? EX1_DR : SH_DR;
      EX1_DR: tap_next = tms ? UPD_DR : PAU_DR;
      PAU_DR: tap_next = tms ? EX2_DR : PAU_DR;
      EX2_DR: tap_next = tms ? UPD_DR : SH_DR;
      UPD_DR: tap_next = tms ? SEL_DR : RTI;
      SEL_IR: tap_next = tms ? TLR : CAP_IR;
      CAP_IR: tap_next = tms ? EX1_IR : SH_IR;
      SH_IR: tap_next = tms ? EX1_IR : SH_IR;
      EX1_IR: tap_next = tms ? UPD_IR : PAU_IR;
      PAU_IR: tap_next = tms ? EX2_IR : PAU_IR;
      EX2_IR: tap_next = tms ? UPD_IR : SH_IR;
      UPD_IR: tap_next = tms ? SEL_IR : RTI;
    endcase
  endfunction : tap_next

  // ************************************************************
  // Instruction decode
  // ************************************************************
  // Edges seen on the second synchroniser stage only
  assign rise = r.tck_s2 & ~r.tck_d;
  assign fall = ~r.tck_s2 & r.tck_d;
  // Boundary chain reachable only while the chain select holds 0011
  assign chain_ok = (r.chain_sel == CHAIN_SEL_BSCAN);
  assign bs_sel = chain_ok & ((r.ir == OP_EXTEST) | (r.ir == OP_SAMPLE) | (r.ir == OP_INTEST));
  assign id_sel = (r.ir == OP_IDCODE);
  assign test_mode = chain_ok & ((r.ir == OP_EXTEST) | (r.ir == OP_INTEST));
  assign clamp_drv = (r.ir == OP_CLAMP);
  assign outs_off = (r.ir == OP_HIGHZ) | (r.ir == OP_CLAMP_OFF);
  // Sample, IDCODE, BYPASS and unknown codes leave everything straight through
  assign SYSTEM_MODE = ~(test_mode | clamp_drv | outs_off);

  // ************************************************************
  // Pad cells
  // ************************************************************
  for (genvar i = 0; i < NPAD; i++)
  begin : g_pad
    // Core sees the latched cell in test mode, else the synchronised pin
    assign CORE_IN[i] = test_mode ? r.bs_upd[3 * i] : r.pin_s2[i];
    // Pin data from cells under test, clamp and clamp-off
    assign PAD_OUT[i] = (test_mode | clamp_drv | (r.ir == OP_CLAMP_OFF)) ? r.bs_upd[3 * i + 1] : CORE_OUT[i];
    // Drivers off for both disabling instructions
    assign PAD_OE[i] = outs_off ? 1'b0 : ((test_mode | clamp_drv) ? r.bs_upd[3 * i + 2] : CORE_OE[i]);
    // INTEST takes the inverted core input, EXTEST what the cells drive
    assign cap_vec[3 * i] = (r.ir == OP_INTEST) ? ~r.bs_upd[3 * i] : r.pin_s2[i];
    assign cap_vec[3 * i + 1] = (r.ir == OP_EXTEST) ? PAD_OUT[i] : CORE_OUT[i];
    assign cap_vec[3 * i + 2] = (r.ir == OP_EXTEST) ? PAD_OE[i] : CORE_OE[i];
  end

  // ************************************************************
  // Link sequencing
  // ************************************************************
  // Stage-one flops feed stage two only; all decisions use stage two
  always_comb
  begin
    next_r = r;
    next_r.tck_s1 = LINK.tck;
    next_r.tck_s2 = r.tck_s1;
    next_r.tck_d = r.tck_s2;
    next_r.tms_s1 = LINK.tms;
    next_r.tms_s2 = r.tms_s1;
    next_r.tdi_s1 = LINK.tdi;
    next_r.tdi_s2 = r.tdi_s1;
    next_r.trst_s1 = LINK.trst_n;
    next_r.trst_s2 = r.trst_s1;
    next_r.pin_s1 = PAD_IN;
    next_r.pin_s2 = r.pin_s1;
    if (!r.trst_s2)
    begin
      // Low test reset, pulse or level, holds reset state
      next_r.st = TLR;
      next_r.ir = OP_IDCODE;
      next_r.chain_sel = CHAIN_SEL_BSCAN;
      next_r.tdo_oe = 1'b0;
    end
    else
    begin
      if (CHAIN_SEL_WE)
        next_r.chain_sel = CHAIN_SEL_WDATA;
      if (rise)
      begin
        next_r.st = tap_next(r.st, r.tms_s2);
        if (r.st == TLR)
          next_r.ir = OP_IDCODE;
        else if (r.st == CAP_IR)
          next_r.ir_sh = IR_CAPTURE;
        else if (r.st == SH_IR)
          next_r.ir_sh = {r.tdi_s2, r.ir_sh[IR_W-1:1]};
        else if (r.st == UPD_IR)
          next_r.ir = r.ir_sh;
        else if (r.st == CAP_DR)
        begin
          if (bs_sel)
            next_r.bs_sh = cap_vec;
          else if (id_sel)
            next_r.id_sh = IDCODE;
          else
            next_r.bypass = 1'b0; // Clamp cells untouched here
        end
        else if (r.st == SH_DR)
        begin
          if (bs_sel)
            next_r.bs_sh = {r.tdi_s2, r.bs_sh[BS_W-1:1]};
          else if (id_sel)
            next_r.id_sh = {r.tdi_s2, r.id_sh[ID_W-1:1]};
          else
            next_r.bypass = r.tdi_s2;
        end
        else if (r.st == UPD_DR && bs_sel)
          next_r.bs_upd = r.bs_sh; // Bypass and ID keep their value
      end
      if (fall)
      begin
        // Output changes only on falling edges, driven only while shifting
        next_r.tdo_oe = (r.st == SH_IR) | (r.st == SH_DR);
        if (r.st == SH_IR)
          next_r.tdo = r.ir_sh[0];
        else if (bs_sel)
          next_r.tdo = r.bs_sh[0];
        else if (id_sel)
          next_r.tdo = r.id_sh[0];
        else
          next_r.tdo = r.bypass;
      end
    end
  end

  // State register
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      r <= RST_VAL;
    else
      r <= next_r;
  end

  assign LINK.tdo = r.tdo;
  assign LINK.tdo_oe = r.tdo_oe;
  assign CHAIN_SEL = r.chain_sel;
  assign INSTR = r.ir;
endmodule : boundary_scan_tap

// ---- test/tap_link_checker.sv ----
// Purpose: Wire checks on the link between master and port
// Assumes: One core clock for both ends
// Notes: Sees interface signals only
`timescale 1ns/100ps
module tap_link_checker
  import tap_pkg::*;
#(
  parameter int TCK_HALF = TCK_HALF_DEFAULT
)
(
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // ****************
  // Link checks
  // ****************
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  logic [7:0] hi_cnt;
  // Length of the running high phase
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      hi_cnt <= 8'h0;
    else
      hi_cnt <= tck ? hi_cnt + 8'h1 : 8'h0;
  end
  AST_TCK_HIGH: assert property ($fell(tck) |-> hi_cnt == 8'(TCK_HALF))
    else $error("tck high span");
  AST_TCK_LOW: assert property ($fell(tck) |-> !tck [*4])
    else $error("tck low span");
  AST_IN_MOVE: assert property ($changed(tms) || $changed(tdi) |-> !tck)
    else $error("tms or tdi moved high");
  AST_TDO_MOVE: assert property ($changed(tdo) |-> !tck && !$past(tck, 2))
    else $error("tdo moved off fall");
  AST_OE_RISE: assert property ($rose(tdo_oe) |-> !tck ##[1:4] $rose(tck))
    else $error("tdo enable late");
  AST_OE_FALL: assert property ($fell(tdo_oe) && trst_n |-> tms && !tck)
    else $error("tdo enable drop");
  AST_TRST_OFF: assert property (!trst_n [*4] |-> !tdo_oe)
    else $error("tdo driven in reset");
  AST_OE_AFTER: assert property (tdo_oe |-> $past(trst_n, 3))
    else $error("tdo driven early");
  // Main traffic seen
  cover property ($rose(tdo_oe));
  cover property ($fell(trst_n));
  cover property ($fell(tdo_oe) && tms);
endmodule : tap_link_checker

// ---- test/boundary_scan_tap_tb_top.sv ----
// Purpose: Runs master and port back to back
// Assumes: Master answers APB in one access cycle
// Notes: Short tck half period keeps the run brief
`timescale 1ns/100ps
module boundary_scan_tap_tb_top
  import tap_pkg::*;
;
  // ****************
  // Bench
  // ****************
  localparam int HALF = 6;
  typedef struct {logic [31:0] e; logic [31:0] m; bit s; logic v;} note_t;
  logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic want = 1'b0, look = 1'b0, sel_we = 1'b0, pready, sys_mode, pslverr;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, g, x = 32'h0000f146;
  logic [3:0] pad_in = 4'h0, core_out = 4'h0, core_oe = 4'h0, sel_wd = 4'h0;
  logic [3:0] pad_out, pad_oe, core_in, chain_sel, instr;
  logic [11:0] upd = 12'h0;
  logic [3:0] ops[8] = '{OP_SAMPLE, OP_EXTEST, OP_CLAMP, OP_HIGHZ, OP_CLAMP_OFF, OP_INTEST, OP_BYPASS, OP_IDCODE};
  int miscompares = 0, comparisons = 0;
  note_t notes[$];
  note_t n;
  wire [31:0] dv = {11'h0, instr, sys_mode, chain_sel, pad_out, pad_oe, core_in};
  tap_link_if tap_link_if_inst ();
  jtag_test_master #(.TCK_HALF(HALF)) jtag_test_master_inst (.CORE_CLK(core_clk), .RST_B(rst_b),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK(tap_link_if_inst.ctl));
  boundary_scan_tap boundary_scan_tap_inst (.CORE_CLK(core_clk), .RST_B(rst_b), .LINK(tap_link_if_inst.dev),
    .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe), .CORE_OUT(core_out), .CORE_OE(core_oe),
    .CORE_IN(core_in), .CHAIN_SEL_WE(sel_we), .CHAIN_SEL_WDATA(sel_wd), .CHAIN_SEL(chain_sel),
    .INSTR(instr), .SYSTEM_MODE(sys_mode));
  tap_link_checker #(.TCK_HALF(HALF)) tap_link_checker_inst (.CORE_CLK(core_clk), .RST_B(rst_b),
    .tck(tap_link_if_inst.tck), .tms(tap_link_if_inst.tms), .tdi(tap_link_if_inst.tdi),
    .trst_n(tap_link_if_inst.trst_n), .tdo(tap_link_if_inst.tdo), .tdo_oe(tap_link_if_inst.tdo_oe));

  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd
  // Chain order: pin, data, enable per pad
  function automatic logic [31:0] weave(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 4; i++) r[3*i +: 3] = {c[i], b[i], a[i]};
    return r;
  endfunction : weave
  function automatic logic [3:0] pick(input int k);
    return {upd[9+k], upd[6+k], upd[3+k], upd[k]};
  endfunction : pick

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input bit c, input logic [31:0] m);
    @(posedge core_clk);
    if (c) notes.push_back('{d, m, 1'b0, !(a inside {REG_CTRL, REG_TX, REG_RX, REG_STATUS})});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    want <= c;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    want <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] e, input logic [31:0] m);
    @(posedge core_clk);
    notes.push_back('{e, m, 1'b1, 1'b0});
    look <= 1'b1;
    @(posedge core_clk);
    look <= 1'b0;
  endtask : chk
  // One shift job; polling is bounded so a stuck master cannot hang us
  task automatic job(input logic [1:0] k, input int len, input logic [31:0] tx, input logic [31:0] e);
    int i = 0;
    apb(1'b1, REG_TX, tx, 1'b0, 32'h0);
    apb(1'b1, REG_CTRL, {15'h0, 1'b1, 3'h0, 5'(len - 1), 5'h0, k, 1'b1}, 1'b0, 32'h0);
    do
    begin
      apb(1'b0, REG_STATUS, 32'h0, 1'b0, 32'h0);
      i++;
    end
    while (rd[STAT_DONE_BIT] !== 1'b1 && i < 3000);
    if (i >= 3000) miscompares++;
    apb(1'b0, REG_RX, e, 1'b1, len == 32 ? 32'hffffffff : (32'h1 << len) - 32'h1);
  endtask : job
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // Oldest note against whatever result shows up
  always @(posedge core_clk)
  begin
    if ((psel && penable && want && pready === 1'b1) || look)
    begin
      n = notes.pop_front();
      g = n.s ? dv : prdata;
      comparisons++;
      if (((g ^ n.e) & n.m) !== 32'h0)
        $display("ERROR %s expected %h seen %h", n.s ? "pins" : "PRDATA", n.e & n.m, g);
      if (((g ^ n.e) & n.m) !== 32'h0)
        miscompares++;
      // Error flag only means something on a bus read
      if (!n.s && pslverr !== n.v)
      begin
        $display("ERROR PSLVERR expected %b seen %b", n.v, pslverr);
        miscompares++;
      end
    end
  end
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    #400000;
    miscompares++;
    complete_run();
  end
  initial
  begin
    logic [3:0] op, po, pe, ci;
    logic [31:0] tx, m;
    logic sm;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    chk({11'h0, OP_IDCODE, 1'b1, CHAIN_SEL_BSCAN, 12'h0}, 32'hffffffff);
    apb(1'b0, 8'h10, 32'h0, 1'b1, 32'hffffffff);
    apb(1'b1, REG_CTRL, 32'h00010000, 1'b0, 32'h0);
    job(KIND_RESET, 1, 32'h0, 32'h0);
    job(KIND_DR, 32, rnd(), IDCODE_DEFAULT);
    $display("reset test done");
    // Sample first so later test modes start from known cells
    foreach (ops[j])
    begin
      op = ops[j];
      tx = rnd();
      pad_in <= tx[15:12];
      core_out <= tx[19:16];
      core_oe <= tx[23:20];
      job(KIND_IR, 4, {28'h0, op}, {28'h0, IR_CAPTURE});
      case (op)
        OP_SAMPLE: job(KIND_DR, 12, tx, weave(pad_in, core_out, core_oe));
        OP_EXTEST: job(KIND_DR, 12, tx, weave(pad_in, pick(1), pick(2)));
        OP_INTEST: job(KIND_DR, 12, tx, weave(~pick(0), core_out, core_oe));
        OP_IDCODE: job(KIND_DR, 32, tx, IDCODE_DEFAULT);
        default: job(KIND_DR, 2, tx, {30'h0, tx[0], 1'b0});
      endcase
      if (op inside {OP_SAMPLE, OP_EXTEST, OP_INTEST}) upd = tx[11:0];
      po = core_out;
      pe = core_oe;
      ci = pad_in;
      sm = 1'b1;
      m = 32'hffffffff;
      if (op inside {OP_EXTEST, OP_INTEST})
      begin
        po = pick(1);
        pe = pick(2);
        ci = pick(0);
        sm = 1'b0;
      end
      if (op inside {OP_CLAMP, OP_HIGHZ, OP_CLAMP_OFF})
      begin
        sm = 1'b0; // Outputs intercepted, so not system mode
        po = op == OP_HIGHZ ? core_out : pick(1);
        pe = op == OP_CLAMP ? pick(2) : 4'h0;
      end
      chk({11'h0, op, sm, CHAIN_SEL_BSCAN, po, pe, ci}, m);
      $display("op %h test done", op);
    end
    sel_wd <= 4'h5;
    sel_we <= 1'b1;
    @(posedge core_clk);
    sel_we <= 1'b0;
    chk(32'h00005000, 32'h0000f000);
    job(KIND_IR, 4, {28'h0, OP_EXTEST}, {28'h0, IR_CAPTURE});
    job(KIND_DR, 2, 32'h1, 32'h2);
    chk(32'h00010000, 32'h00010000);
    apb(1'b1, REG_CTRL, 32'h0, 1'b0, 32'h0);
    repeat (8) @(posedge core_clk);
    chk({11'h0, OP_IDCODE, 1'b1, CHAIN_SEL_BSCAN, core_out, core_oe, pad_in}, 32'hffffffff);
    $display("chain select test done");
    complete_run();
  end
endmodule : boundary_scan_tap_tb_top
